// *** include/csp_defs.vh ***
// Frame timing constants for the codec serial frame port
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH
`define CSP_WORD_BITS 16
`define CSP_FRAME_SCLKS 256
`define CSP_CNT_W 8
`define CSP_BIT_CNT_W 5
`define CSP_LAST_BIT 5'h0F
`define CSP_SEC_SLOT 8'h80
`define CSP_SCLK_HALF_DEF 4
`define CSP_DIV_W 8
`define CSP_SW_REQ_BIT 0
`endif

// *** src/csp_buf2.v ***
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module csp_buf2 #(
    parameter WIDTH = 16
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem_ff [0:1];
    reg wr_ptr_ff;
    reg rd_ptr_ff;
    reg [1:0] cnt_ff;
    reg in_ready_ff;
    reg out_valid_ff;
    wire push = in_valid_i && in_ready_ff;
    wire pop = out_valid_ff && out_ready_i;
    reg [1:0] nxt_cnt;

    always @* begin
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
            in_ready_ff <= 1'b1;
            out_valid_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= nxt_cnt;
            // Flags registered so ready never depends on the drain side combinationally
            in_ready_ff <= (nxt_cnt != 2'h2);
            out_valid_ff <= (nxt_cnt != 2'h0);
        end
    end

    always @(posedge ref_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    assign in_ready_o = in_ready_ff;
    assign out_valid_o = out_valid_ff;
    assign out_data_o = mem_ff[rd_ptr_ff];
endmodule // csp_buf2
`default_nettype wire

// *** src/csp_port.v ***
// Framed synchronous serial port of a sigma-delta voice codec
// Function
// - Master when master/slave select is high, slave when low.
// - Low power_down_n enters power-down and disables the serial port.
// - Power-down clears counters and transfer state only; held settings survive and operation resumes.
// - Hardware reset loads every register with its default value; the buffer's word storage (mem_ff) has no reset.
// - Master drives shift_clock at 256 times the frame_sync_n rate.
// - During frame sync, one bit in and one bit out per shift clock.
// - Each transfer is 16 shift clocks, starting at frame_sync_n falling edge.
// - Primary frame syncs fall exactly 256 shift clocks apart.
// - frame_sync_n returns high on the seventeenth rising shift clock edge.
// - ADC word out and DAC word in move in the same window.
// - Secondary transfer only on hardware request or software request bit.
// - Primary sync starts primary transfer; secondary sync starts secondary transfer.
// - Master generates frame_sync_n, low during transfer; slave takes it as input.
// - secondary_request sampled at frame_sync_n rising edge ending primary transfer.
// - delayed_frame_sync copies frame sync, delayed by programmed shift clocks.
// - Launch serial_out on rising shift clock, capture serial_in on falling.
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.vh"
module csp_port #(
    parameter SCLK_HALF = `CSP_SCLK_HALF_DEF
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire master_sel_i,
    input wire power_down_n_i,
    input wire shift_clock_i,
    output wire shift_clock_o,
    output wire shift_clock_oe_o,
    input wire frame_sync_n_i,
    output wire frame_sync_n_o,
    output wire frame_sync_n_oe_o,
    output wire delayed_frame_sync_n_o,
    input wire [`CSP_CNT_W-1:0] fsd_delay_i,
    input wire serial_in_i,
    output wire serial_out_o,
    input wire secondary_request_i,
    input wire [`CSP_WORD_BITS-1:0] adc_data_i,
    input wire adc_valid_i,
    output wire adc_ready_o,
    input wire [`CSP_WORD_BITS-1:0] sec_tx_data_i,
    output wire [`CSP_WORD_BITS-1:0] rx_data_o,
    output wire rx_valid_o,
    output wire rx_secondary_o
);
    // Pin synchronisers, two flops each
    reg [1:0] ms_sync_ff, pd_sync_ff, sck_sync_ff, fs_sync_ff, din_sync_ff, req_sync_ff;
    reg sck_prev_ff;
    reg [`CSP_DIV_W-1:0] div_ff;
    reg sclk_ff;
    reg [`CSP_CNT_W-1:0] fcnt_ff;
    reg busy_ff, sec_act_ff, sec_pend_ff, sec_seen_ff, fs_armed_ff, sw_req_ff;
    reg [`CSP_BIT_CNT_W-1:0] bcnt_ff, rcnt_ff;
    reg [`CSP_WORD_BITS-1:0] txsh_ff, rxsh_ff, rx_data_ff;
    reg sout_ff, fs_ff, dfs_ff, rx_valid_ff, rx_sec_ff, sck_oe_ff, fs_oe_ff;

    wire is_master = ms_sync_ff[1];
    wire run = pd_sync_ff[1];
    wire div_end = (div_ff == SCLK_HALF[`CSP_DIV_W-1:0] - 8'h01);
    wire rise_m = run && is_master && div_end && !sclk_ff;
    wire fall_m = run && is_master && div_end && sclk_ff;
    // Slave edges found on the second sync stage against its own delayed copy
    wire rise_s = run && !is_master && sck_sync_ff[1] && !sck_prev_ff;
    wire fall_s = run && !is_master && !sck_sync_ff[1] && sck_prev_ff;
    wire rise = rise_m || rise_s;
    wire fall = fall_m || fall_s;
    wire fs_in_low = !fs_sync_ff[1];

    // Master starts at slot 0 and, if pending, at the secondary slot
    wire start_m_pri = rise_m && !busy_ff && (fcnt_ff == 8'h00);
    wire start_m_sec = rise_m && !busy_ff && sec_pend_ff && (fcnt_ff == `CSP_SEC_SLOT);
    wire start_s = rise_s && !busy_ff && fs_armed_ff && fs_in_low;
    wire start = start_m_pri || start_m_sec || start_s;
    wire start_sec = start_m_sec || (start_s && sec_pend_ff);

    wire buf_valid;
    wire [`CSP_WORD_BITS-1:0] buf_data;
    wire buf_pop = start && !start_sec && buf_valid;
    // Empty buffer sends a zero word rather than stalling the frame
    wire [`CSP_WORD_BITS-1:0] tx_word = start_sec ? sec_tx_data_i :
                                       (buf_valid ? buf_data : 16'h0000);
    wire [`CSP_CNT_W-1:0] dpos = fcnt_ff - fsd_delay_i;

    csp_buf2 #(
        .WIDTH(`CSP_WORD_BITS)
    ) u_adc_buf (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(adc_data_i),
        .in_valid_i(adc_valid_i),
        .in_ready_o(adc_ready_o),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop)
    );

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ms_sync_ff <= 2'h0;
            pd_sync_ff <= 2'h0;
            sck_sync_ff <= 2'h0;
            fs_sync_ff <= 2'h3;
            din_sync_ff <= 2'h0;
            req_sync_ff <= 2'h0;
            sck_prev_ff <= 1'b0;
        end else begin
            ms_sync_ff <= {ms_sync_ff[0], master_sel_i};
            pd_sync_ff <= {pd_sync_ff[0], power_down_n_i};
            sck_sync_ff <= {sck_sync_ff[0], shift_clock_i};
            fs_sync_ff <= {fs_sync_ff[0], frame_sync_n_i};
            din_sync_ff <= {din_sync_ff[0], serial_in_i};
            req_sync_ff <= {req_sync_ff[0], secondary_request_i};
            sck_prev_ff <= sck_sync_ff[1];
        end
    end

    always @(posedge ref_clk_i) begin
        // Power-down clears only counters and transfer state; the buffer keeps its words
        if (!rst_n_i || !run) begin
            div_ff <= 8'h00;
            sclk_ff <= 1'b0;
            fcnt_ff <= 8'h00;
            busy_ff <= 1'b0;
            sec_act_ff <= 1'b0;
            sec_pend_ff <= 1'b0;
            sec_seen_ff <= 1'b0;
            fs_armed_ff <= 1'b0;
            sw_req_ff <= 1'b0;
            bcnt_ff <= 5'h00;
            rcnt_ff <= 5'h00;
            txsh_ff <= 16'h0000;
            rxsh_ff <= 16'h0000;
            rx_data_ff <= 16'h0000;
            sout_ff <= 1'b0;
            fs_ff <= 1'b1;
            dfs_ff <= 1'b1;
            rx_valid_ff <= 1'b0;
            rx_sec_ff <= 1'b0;
            sck_oe_ff <= 1'b0;
            fs_oe_ff <= 1'b0;
        end else begin
            sck_oe_ff <= is_master;
            fs_oe_ff <= is_master;
            rx_valid_ff <= 1'b0;
            if (is_master) begin
                div_ff <= div_end ? 8'h00 : div_ff + 8'h01;
                if (div_end) begin
                    sclk_ff <= ~sclk_ff;
                end
            end else begin
                div_ff <= 8'h00;
                sclk_ff <= 1'b0;
            end
            if (rise_s && !fs_in_low) begin
                fs_armed_ff <= 1'b1;
            end
            if (rise) begin
                // 8-bit count wraps every 256 shift clocks
                fcnt_ff <= (start_s && !start_sec) ? 8'h01 : fcnt_ff + 8'h01;
                dfs_ff <= !((dpos[7:4] == 4'h0) ||
                            (sec_seen_ff && dpos[7:4] == 4'h8));
            end
            if (start) begin
                busy_ff <= 1'b1;
                sec_act_ff <= start_sec;
                fs_armed_ff <= 1'b0;
                bcnt_ff <= 5'h00;
                rcnt_ff <= 5'h00;
                fs_ff <= 1'b0;
                sout_ff <= tx_word[15];
                txsh_ff <= {tx_word[14:0], 1'b0};
                if (start_sec) begin
                    sec_pend_ff <= 1'b0;
                    sec_seen_ff <= 1'b1;
                end else begin
                    sec_seen_ff <= 1'b0;
                end
            end else if (rise && busy_ff) begin
                if (bcnt_ff == `CSP_LAST_BIT) begin
                    busy_ff <= 1'b0;
                    fs_ff <= 1'b1;
                    sout_ff <= 1'b0;
                    if (!sec_act_ff) begin
                        sec_pend_ff <= req_sync_ff[1] || sw_req_ff;
                    end
                end else begin
                    bcnt_ff <= bcnt_ff + 5'h01;
                    sout_ff <= txsh_ff[15];
                    txsh_ff <= {txsh_ff[14:0], 1'b0};
                end
            end
            if (fall && busy_ff && rcnt_ff <= `CSP_LAST_BIT) begin
                rxsh_ff <= {rxsh_ff[14:0], din_sync_ff[1]};
                rcnt_ff <= rcnt_ff + 5'h01;
                if (rcnt_ff == `CSP_LAST_BIT) begin
                    rx_data_ff <= {rxsh_ff[14:0], din_sync_ff[1]};
                    rx_valid_ff <= 1'b1;
                    rx_sec_ff <= sec_act_ff;
                    // Low data bit of a primary word doubles as the software request
                    sw_req_ff <= !sec_act_ff && din_sync_ff[1];
                end
            end
            // A frame cut by a mode switch ends at once, so no stale sync low is driven
            if (fs_oe_ff != is_master) begin
                busy_ff <= 1'b0;
                fs_ff <= 1'b1;
                sout_ff <= 1'b0;
            end
        end
    end

    assign shift_clock_o = sclk_ff;
    assign shift_clock_oe_o = sck_oe_ff;
    assign frame_sync_n_o = fs_ff;
    assign frame_sync_n_oe_o = fs_oe_ff;
    assign delayed_frame_sync_n_o = dfs_ff;
    assign serial_out_o = sout_ff;
    assign rx_data_o = rx_data_ff;
    assign rx_valid_o = rx_valid_ff;
    assign rx_secondary_o = rx_sec_ff;
endmodule // csp_port
`default_nettype wire

// *** test/csp_host_model.sv ***
// Host serial port model at the far side of the codec serial frame port
`timescale 1ns/100ps
`default_nettype none
module csp_host_model (
    input wire sclk_i,
    input wire fs_n_i,
    input wire dout_i,
    input wire [15:0] tx_word_i,
    output logic sclk_o = 1'b0,
    output logic fs_n_o = 1'b1,
    output logic din_o = 1'b0,
    output logic [15:0] rx_word_o = 16'h0000,
    output logic [7:0] rx_cnt_o = 8'h00
);
    logic [7:0] hc = 8'hF0;
    logic [15:0] sh = 16'h0000;
    integer nb = 0;
    integer ob = 0;
    // Free running, as the shift clock is tied to the sample rate
    always #100 sclk_o = ~sclk_o;
    always @(negedge sclk_o) begin
        hc <= hc + 8'h01;
        fs_n_o <= (hc + 8'h01) > 8'h0F;
    end
    always @(posedge sclk_i) begin
        #1;
        if (!fs_n_i && ob < 16) begin
            din_o = tx_word_i[15 - ob];
            ob = ob + 1;
        end else begin
            ob = fs_n_i ? 0 : ob;
            // Released line toggles so a stale bit is never mistaken for data
            din_o = ~din_o;
        end
    end
    always @(negedge sclk_i) begin
        if (!fs_n_i) begin
            sh = {sh[14:0], dout_i};
            nb = nb + 1;
            if (nb == 16) begin
                rx_word_o = sh;
                rx_cnt_o = rx_cnt_o + 8'h01;
            end
        end else begin
            nb = 0;
        end
    end
endmodule // csp_host_model
`default_nettype wire

// *** test/csp_port_asserts.sv ***
// Assertion checker for the codec serial frame port
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.vh"
module csp_port_asserts #(
    parameter SCLK_HALF = `CSP_SCLK_HALF_DEF
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire master_sel_i,
    input wire power_down_n_i,
    input wire shift_clock_o,
    input wire shift_clock_oe_o,
    input wire frame_sync_n_o,
    input wire frame_sync_n_oe_o,
    input wire serial_out_o,
    input wire rx_valid_o
);
    localparam int PER = 2 * SCLK_HALF;
    localparam int SLOT = 128 * PER;
    logic [15:0] low_ff;
    logic [15:0] gap_ff;
    logic seen_ff;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Cleared while the master is silent, so a resume is never judged against old frames
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !shift_clock_oe_o) begin
            low_ff <= 16'h0000;
            gap_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else begin
            low_ff <= frame_sync_n_o ? 16'h0000 : low_ff + 16'h0001;
            gap_ff <= $fell(frame_sync_n_o) ? 16'h0001 : gap_ff + 16'h0001;
            seen_ff <= seen_ff | $fell(frame_sync_n_o);
        end
    end
    a_slave_quiet: assert property (
        (!master_sel_i) [*4] |-> !shift_clock_oe_o && !frame_sync_n_oe_o)
        else $error("slave drives clock or sync");
    a_master_drive: assert property (
        (master_sel_i && power_down_n_i) [*6] |-> shift_clock_oe_o && frame_sync_n_oe_o)
        else $error("master not driving clock and sync");
    a_pd_quiet: assert property (
        (!power_down_n_i) [*4] |-> !shift_clock_oe_o && frame_sync_n_o && !serial_out_o)
        else $error("port active in power-down");
    a_sclk_period: assert property (
        $rose(shift_clock_o) && shift_clock_oe_o |-> ##PER ($rose(shift_clock_o) || !shift_clock_oe_o))
        else $error("shift clock period wrong");
    a_fs_edges: assert property (
        $changed(frame_sync_n_o) && shift_clock_oe_o && power_down_n_i
        && $past(power_down_n_i, 3) |-> $rose(shift_clock_o))
        else $error("frame sync moved off a shift clock rise");
    a_fs_width: assert property (
        $rose(frame_sync_n_o) && shift_clock_oe_o |-> low_ff == 16 * PER)
        else $error("frame sync low time wrong");
    a_frame_gap: assert property (
        $fell(frame_sync_n_o) && seen_ff |-> gap_ff == SLOT || gap_ff == 2 * SLOT)
        else $error("frame sync spacing wrong");
    a_idle_out: assert property (
        shift_clock_oe_o && frame_sync_n_o |-> !serial_out_o)
        else $error("data out active outside frame");
    a_rx_window: assert property (
        rx_valid_o && shift_clock_oe_o |-> ##[1:PER] $rose(frame_sync_n_o))
        else $error("word received outside frame window");
    c_secondary: cover property ($fell(frame_sync_n_o) && seen_ff && gap_ff == SLOT);
    c_resume: cover property ($rose(power_down_n_i));
    c_slave_rx: cover property (rx_valid_o && !master_sel_i);
endmodule // csp_port_asserts
bind csp_port csp_port_asserts #(.SCLK_HALF(SCLK_HALF)) u_asserts (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .master_sel_i(master_sel_i),
    .power_down_n_i(power_down_n_i), .shift_clock_o(shift_clock_o),
    .shift_clock_oe_o(shift_clock_oe_o), .frame_sync_n_o(frame_sync_n_o),
    .frame_sync_n_oe_o(frame_sync_n_oe_o), .serial_out_o(serial_out_o), .rx_valid_o(rx_valid_o));
`default_nettype wire

// *** test/csp_port_tb.sv ***
// Self-checking bench for the codec serial frame port
`timescale 1ns/100ps
`default_nettype none
module csp_port_tb;
    localparam int PER = 8;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic master_sel_i = 1'b1;
    logic power_down_n_i = 1'b1;
    logic secondary_request_i = 1'b0;
    logic adc_valid_i = 1'b0;
    logic [7:0] fsd_delay_i = 8'h03;
    logic [15:0] adc_data_i = 16'h0000;
    logic [15:0] sec_tx_data_i = 16'h8421;
    logic [15:0] host_tx = 16'h3C5A;
    logic [7:0] h_last = 8'h00;
    wire sclk_o, sclk_oe, fs_o, fs_oe, fsd_n, dout, adc_ready, rx_valid, rx_sec, h_sclk, h_fs, din;
    wire [15:0] rx_data;
    wire [15:0] h_word;
    wire [7:0] h_cnt;
    // Released master lines rest at their pull levels; the host drives them only in slave mode
    wire sclk_w = sclk_oe ? sclk_o : (master_sel_i ? 1'b0 : h_sclk);
    wire fs_w = fs_oe ? fs_o : (master_sel_i ? 1'b1 : h_fs);
    integer fails = 0;
    integer samples_checked = 0;
    integer n;
    integer k;
    always #12.5 ref_clk_i = ~ref_clk_i;
    csp_port #(.SCLK_HALF(4)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .master_sel_i(master_sel_i), .power_down_n_i(power_down_n_i), .shift_clock_i(sclk_w),
        .shift_clock_o(sclk_o), .shift_clock_oe_o(sclk_oe), .frame_sync_n_i(fs_w),
        .frame_sync_n_o(fs_o), .frame_sync_n_oe_o(fs_oe), .delayed_frame_sync_n_o(fsd_n),
        .fsd_delay_i(fsd_delay_i), .serial_in_i(din), .serial_out_o(dout),
        .secondary_request_i(secondary_request_i), .adc_data_i(adc_data_i),
        .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready), .sec_tx_data_i(sec_tx_data_i),
        .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_secondary_o(rx_sec));
    csp_host_model host (.sclk_i(sclk_w), .fs_n_i(fs_w), .dout_i(dout), .tx_word_i(host_tx),
        .sclk_o(h_sclk), .fs_n_o(h_fs), .din_o(din), .rx_word_o(h_word), .rx_cnt_o(h_cnt));
    task automatic results;
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait: 0 frame sync, 1 delayed sync, 2 received word, 3 host word
    task automatic seek(input int sel, input logic v);
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while ((sel == 0 ? fs_o : sel == 1 ? fsd_n : sel == 2 ? rx_valid :
            (h_cnt != h_last)) !== v && n < 5000);
        if (n >= 5000) begin
            fails++;
            results;
        end
    endtask
    task automatic push(input logic [15:0] w);
        @(negedge ref_clk_i);
        adc_data_i = w;
        adc_valid_i = 1'b1;
        @(negedge ref_clk_i);
        adc_valid_i = 1'b0;
    endtask
    task automatic t_master;
        seek(2, 1'b1);
        push(16'hA5C3);
        h_last = h_cnt;
        seek(3, 1'b1);
        chk(h_word, 16'hA5C3);
        seek(2, 1'b1);
        chk(rx_data, host_tx);
        chk({15'h0000, rx_sec}, 16'h0000);
    endtask
    task automatic t_delay(input int d);
        @(negedge ref_clk_i);
        fsd_delay_i = 8'(d);
        seek(0, 1'b1);
        seek(0, 1'b0);
        seek(1, 1'b0);
        chk(16'(n), 16'(d * PER));
        seek(1, 1'b1);
        chk(16'(n), 16'(16 * PER));
    endtask
    task automatic t_secondary;
        for (k = 0; k < 2; k++) begin
            seek(2, 1'b1);
            @(negedge ref_clk_i);
            secondary_request_i = (k == 0);
            host_tx = (k == 0) ? 16'h3C5A : 16'h3C5B;
            seek(2, 1'b1);
            if (rx_sec !== 1'b1) seek(2, 1'b1);
            if (rx_sec !== 1'b1) seek(2, 1'b1);
            chk({15'h0000, rx_sec}, 16'h0001);
            chk(h_word, sec_tx_data_i);
            @(negedge ref_clk_i);
            secondary_request_i = 1'b0;
            host_tx = 16'h3C5A;
            seek(2, 1'b1);
            seek(2, 1'b1);
            chk({15'h0000, rx_sec}, 16'h0000);
        end
    endtask
    task automatic t_buffer;
        seek(2, 1'b1);
        push(16'h1111);
        push(16'h2222);
        chk({15'h0000, adc_ready}, 16'h0000);
        for (k = 0; k < 3; k++) begin
            h_last = h_cnt;
            seek(3, 1'b1);
            chk(h_word, k == 0 ? 16'h1111 : k == 1 ? 16'h2222 : 16'h0000);
        end
        chk({15'h0000, adc_ready}, 16'h0001);
    endtask
    task automatic t_powerdown;
        seek(2, 1'b1);
        push(16'h5AA5);
        @(negedge ref_clk_i);
        power_down_n_i = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        chk({12'h000, sclk_oe, fs_oe, fs_o, dout}, 16'h0002);
        repeat (14) @(negedge ref_clk_i);
        power_down_n_i = 1'b1;
        h_last = h_cnt;
        seek(3, 1'b1);
        chk(h_word, 16'h5AA5);
    endtask
    task automatic t_slave;
        @(negedge ref_clk_i);
        master_sel_i = 1'b0;
        host_tx = 16'h1234;
        repeat (6) @(negedge ref_clk_i);
        chk({14'h0000, sclk_oe, fs_oe}, 16'h0000);
        seek(2, 1'b1);
        seek(2, 1'b1);
        chk(rx_data, 16'h1234);
    endtask
    initial begin
        repeat (4) @(negedge ref_clk_i);
        chk({7'h00, sclk_oe, fs_oe, fs_o, fsd_n, dout, adc_ready, rx_valid, rx_sec, sclk_o},
            16'h0068);
        chk(rx_data, 16'h0000);
        rst_n_i = 1'b1;
        t_master;
        t_delay(3);
        t_delay(7);
        t_secondary;
        t_buffer;
        t_powerdown;
        t_slave;
        results;
    end
endmodule // csp_port_tb
`default_nettype wire
